// >>> hw/port_irq_ctrl.sv
// Added by the designer: the plain strobed port.
`timescale 1ns/10ps

module port_irq_ctrl
  import port_irq_pkg::*;
#(
  parameter int P0_W = port_irq_pkg::PORT0_W,
  parameter int P1_W = port_irq_pkg::PORT1_W,
  parameter int P2_W = port_irq_pkg::PORT2_W
) (
  input  wire logic                            mclk,
  input  wire logic                            rst,
  input  wire logic [port_irq_pkg::ADDR_W-1:0] addr,
  input  wire logic [port_irq_pkg::DATA_W-1:0] wr_data,
  input  wire logic                            wr_en,
  input  wire logic                            rd_en,
  output logic      [port_irq_pkg::DATA_W-1:0] rd_data,
  input  wire logic [P0_W-1:0]                 port0_pins,
  input  wire logic [P1_W-1:0]                 port1_pins,
  input  wire logic [P2_W-1:0]                 port2_pins,
  output logic                                 pad_drive_strength_select,
  output logic                                 port0_irq_req,
  output logic                                 port1_irq_req,
  output logic                                 port2_irq_req,
  output logic                                 irq
);

  import port_irq_pkg::*;

  typedef struct packed {
    logic [DATA_W-1:0] ctrl;
    logic [P0_W-1:0]   port0_pending_flags;
    logic [P1_W-1:0]   port1_pending_flags;
    logic [P2_W-1:0]   port2_pending_flags;
    logic [P1_W-1:0]   port1_pin_irq_mask;
    logic [EVT_W-1:0]  irq_status;
    logic [EVT_W-1:0]  irq_mask;
    logic [EVT_W-1:0]  req;
    logic              irq;
    logic [DATA_W-1:0] rd_data;
  } state_t;

  state_t st_q;
  state_t st_d;

  logic [P0_W-1:0] port0_edges;
  logic [P1_W-1:0] port1_edges;
  logic [P2_W-1:0] port2_edges;

  logic port0_edge_select;
  logic port1_edge_select;
  logic port2_edge_select;
  logic port0_upper_irq_enable;
  logic port0_lower_irq_enable;
  logic port2_group_irq_enable;

  logic [P0_W-1:0] port0_pin_enable;
  logic [P1_W-1:0] port1_pin_enable;
  logic [P2_W-1:0] port2_pin_enable;

  logic [EVT_W-1:0] evt;

  // hardware-set flag with software clear; a set in the clearing cycle wins
  function automatic logic [DATA_W-1:0] flag_next(
    input logic [DATA_W-1:0] cur,
    input logic [DATA_W-1:0] set,
    input logic              wr_hit,
    input logic [DATA_W-1:0] wdata,
    input logic [DATA_W-1:0] clr_zero
  );
    logic [DATA_W-1:0] kept;
    kept = cur;
    if (wr_hit)
    begin
      kept = cur & (wdata | ~clr_zero);
    end
    return kept | set;
  endfunction

  function automatic logic any_masked(
    input logic [DATA_W-1:0] v,
    input logic [DATA_W-1:0] m
  );
    return |(v & m);
  endfunction

  assign port0_edge_select      = st_q.ctrl[BIT_PORT0_EDGE];
  assign port1_edge_select      = st_q.ctrl[BIT_PORT1_EDGE];
  assign port2_edge_select      = st_q.ctrl[BIT_PORT2_EDGE];
  assign port0_lower_irq_enable = st_q.ctrl[BIT_PORT0_LO_EN];
  assign port0_upper_irq_enable = st_q.ctrl[BIT_PORT0_HI_EN];
  assign port2_group_irq_enable = st_q.ctrl[BIT_PORT2_EN];

  pin_edge_detect #(
    .WIDTH (P0_W)
  ) u_port0_edges (
    .mclk    (mclk),
    .rst     (rst),
    .pins    (port0_pins),
    .falling (port0_edge_select),
    .edges   (port0_edges)
  );

  pin_edge_detect #(
    .WIDTH (P1_W)
  ) u_port1_edges (
    .mclk    (mclk),
    .rst     (rst),
    .pins    (port1_pins),
    .falling (port1_edge_select),
    .edges   (port1_edges)
  );

  // one select bit for the whole group, no per-pin choice
  pin_edge_detect #(
    .WIDTH (P2_W)
  ) u_port2_edges (
    .mclk    (mclk),
    .rst     (rst),
    .pins    (port2_pins),
    .falling (port2_edge_select),
    .edges   (port2_edges)
  );

  // group enables of ports 0 and 2 widened to per-pin masks; port 1 takes its mask register
  always_comb
  begin
    port0_pin_enable = '0;
    for (int i = 0; i < P0_W; i++)
    begin
      if (i >= PORT0_HALF)
      begin
        port0_pin_enable[i] = port0_upper_irq_enable;
      end
      else
      begin
        port0_pin_enable[i] = port0_lower_irq_enable;
      end
    end
    port1_pin_enable = st_q.port1_pin_irq_mask;
    port2_pin_enable = {P2_W{port2_group_irq_enable}};
  end

  // status events fire only on edges that are enabled when they land
  always_comb
  begin
    evt            = '0;
    evt[EVT_PORT0] = any_masked(DATA_W'(port0_edges), DATA_W'(port0_pin_enable));
    evt[EVT_PORT1] = any_masked(DATA_W'(port1_edges), DATA_W'(port1_pin_enable));
    evt[EVT_PORT2] = any_masked(DATA_W'(port2_edges), DATA_W'(port2_pin_enable));
  end

  always_comb
  begin
    logic              wr_p0;
    logic              wr_p1;
    logic              wr_p2;
    logic [DATA_W-1:0] f0;
    logic [DATA_W-1:0] f1;
    logic [DATA_W-1:0] f2;
    logic [DATA_W-1:0] ones;
    wr_p0 = 1'b0;
    wr_p1 = 1'b0;
    wr_p2 = 1'b0;
    f0    = '0;
    f1    = '0;
    f2    = '0;
    ones  = '1;
    st_d  = st_q;

    wr_p0 = wr_en && (addr == OFS_PORT0_FLAGS);
    wr_p1 = wr_en && (addr == OFS_PORT1_FLAGS);
    wr_p2 = wr_en && (addr == OFS_PORT2_FLAGS);

    // flags set on every qualifying edge, enabled or not
    f0 = flag_next(DATA_W'(st_q.port0_pending_flags), DATA_W'(port0_edges),
                   wr_p0, wr_data, ones);
    f1 = flag_next(DATA_W'(st_q.port1_pending_flags), DATA_W'(port1_edges),
                   wr_p1, wr_data, ones);
    f2 = flag_next(DATA_W'(st_q.port2_pending_flags), DATA_W'(port2_edges),
                   wr_p2, wr_data, ones);
    st_d.port0_pending_flags = f0[P0_W-1:0];
    st_d.port1_pending_flags = f1[P1_W-1:0];
    st_d.port2_pending_flags = f2[P2_W-1:0];

    if (wr_en)
    begin
      case (addr)
        OFS_PORT_CTRL:
        begin
          st_d.ctrl = wr_data & CTRL_WMASK;
        end
        OFS_PORT1_MASK:
        begin
          st_d.port1_pin_irq_mask = wr_data[P1_W-1:0];
        end
        OFS_IRQ_MASK:
        begin
          st_d.irq_mask = wr_data[EVT_W-1:0];
        end
        default:
        begin
          st_d.ctrl = st_q.ctrl;
        end
      endcase
    end

    // write one to clear; a fresh event in the same cycle survives
    st_d.irq_status = st_q.irq_status;
    if (wr_en && (addr == OFS_IRQ_STATUS))
    begin
      st_d.irq_status = st_q.irq_status & ~wr_data[EVT_W-1:0];
    end
    st_d.irq_status = st_d.irq_status | evt;

    // level requests toward the interrupt controller track pending flags of enabled pins
    st_d.req[EVT_PORT0] = any_masked(DATA_W'(st_d.port0_pending_flags),
                                     DATA_W'(port0_pin_enable));
    st_d.req[EVT_PORT1] = any_masked(DATA_W'(st_d.port1_pending_flags),
                                     DATA_W'(port1_pin_enable));
    st_d.req[EVT_PORT2] = any_masked(DATA_W'(st_d.port2_pending_flags),
                                     DATA_W'(port2_pin_enable));

    st_d.irq = |(st_d.irq_status & st_d.irq_mask);

    // read data stands for one cycle only, zero otherwise
    st_d.rd_data = '0;
    if (rd_en)
    begin
      case (addr)
        OFS_PORT0_FLAGS:
        begin
          st_d.rd_data = DATA_W'(st_q.port0_pending_flags);
        end
        OFS_PORT1_FLAGS:
        begin
          st_d.rd_data = DATA_W'(st_q.port1_pending_flags);
        end
        OFS_PORT2_FLAGS:
        begin
          st_d.rd_data = DATA_W'(st_q.port2_pending_flags);
        end
        OFS_PORT_CTRL:
        begin
          st_d.rd_data = st_q.ctrl & CTRL_WMASK;
        end
        OFS_PORT1_MASK:
        begin
          st_d.rd_data = DATA_W'(st_q.port1_pin_irq_mask);
        end
        OFS_IRQ_STATUS:
        begin
          st_d.rd_data = DATA_W'(st_q.irq_status);
        end
        OFS_IRQ_MASK:
        begin
          st_d.rd_data = DATA_W'(st_q.irq_mask);
        end
        default:
        begin
          st_d.rd_data = UNMAPPED_READ;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      st_q.ctrl                <= CTRL_RESET;
      st_q.port0_pending_flags <= FLAGS_RESET[P0_W-1:0];
      st_q.port1_pending_flags <= FLAGS_RESET[P1_W-1:0];
      st_q.port2_pending_flags <= FLAGS_RESET[P2_W-1:0];
      st_q.port1_pin_irq_mask  <= MASK_RESET[P1_W-1:0];
      st_q.irq_status          <= IRQ_RESET;
      st_q.irq_mask            <= IRQ_RESET;
      st_q.req                 <= IRQ_RESET;
      st_q.irq                 <= 1'b0;
      st_q.rd_data             <= '0;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  // pad setting is only held here; the pad cells act on it
  assign pad_drive_strength_select = st_q.ctrl[BIT_PAD_DRIVE];
  assign port0_irq_req             = st_q.req[EVT_PORT0];
  assign port1_irq_req             = st_q.req[EVT_PORT1];
  assign port2_irq_req             = st_q.req[EVT_PORT2];
  assign irq                       = st_q.irq;
  assign rd_data                   = st_q.rd_data;

endmodule

// >>> shared/port_irq_pkg.sv
package port_irq_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;

  localparam int PORT0_W = 8;
  localparam int PORT1_W = 8;
  localparam int PORT2_W = 5;
  localparam int PORT0_HALF = 4;
  localparam int EVT_W = 3;

  localparam logic [7:0] OFS_PORT0_FLAGS = 8'h89;
  localparam logic [7:0] OFS_PORT1_FLAGS = 8'h8a;
  localparam logic [7:0] OFS_PORT2_FLAGS = 8'h8b;
  localparam logic [7:0] OFS_PORT_CTRL   = 8'h8c;
  localparam logic [7:0] OFS_PORT1_MASK  = 8'h8d;
  localparam logic [7:0] OFS_IRQ_STATUS  = 8'h90;
  localparam logic [7:0] OFS_IRQ_MASK    = 8'h91;

  localparam int BIT_PORT0_EDGE  = 0;
  localparam int BIT_PORT1_EDGE  = 1;
  localparam int BIT_PORT2_EDGE  = 2;
  localparam int BIT_PORT0_LO_EN = 3;
  localparam int BIT_PORT0_HI_EN = 4;
  localparam int BIT_PORT2_EN    = 5;
  localparam int BIT_PAD_DRIVE   = 6;

  localparam logic [7:0] CTRL_WMASK    = 8'h7f;
  localparam logic [7:0] CTRL_RESET    = 8'h00;
  localparam logic [7:0] FLAGS_RESET   = 8'h00;
  localparam logic [7:0] MASK_RESET    = 8'h00;
  localparam logic [2:0] IRQ_RESET     = 3'h0;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  localparam int EVT_PORT0 = 0;
  localparam int EVT_PORT1 = 1;
  localparam int EVT_PORT2 = 2;

endpackage

// >>> hw/pin_edge_detect.sv
`timescale 1ns/10ps

module pin_edge_detect #(
  parameter int WIDTH = 8
) (
  input  wire logic             mclk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] pins,
  input  wire logic             falling,
  output logic      [WIDTH-1:0] edges
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] sync;
    logic [WIDTH-1:0] prev;
  } edge_state_t;

  edge_state_t st_q;
  edge_state_t st_d;

  always_comb
  begin
    st_d      = st_q;
    st_d.meta = pins;
    st_d.sync = st_q.meta;
    st_d.prev = st_q.sync;
  end

  // compare synced sample with previous one; meta stage is never looked at
  always_comb
  begin
    if (falling)
    begin
      edges = st_q.prev & ~st_q.sync;
    end
    else
    begin
      edges = st_q.sync & ~st_q.prev;
    end
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      st_q <= '0;
    end
    else
    begin
      st_q <= st_d;
    end
  end

endmodule

// >>> test/port_irq_ctrl_assertions.sv
`timescale 1ns/10ps
module port_irq_ctrl_assertions
  import port_irq_pkg::*;
#(
  parameter int P0_W = PORT0_W,
  parameter int P1_W = PORT1_W,
  parameter int P2_W = PORT2_W
) (
  input wire logic              mclk,
  input wire logic              rst,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wr_data,
  input wire logic              wr_en,
  input wire logic              rd_en,
  input wire logic [DATA_W-1:0] rd_data,
  input wire logic [P0_W-1:0]   port0_pins,
  input wire logic [P1_W-1:0]   port1_pins,
  input wire logic [P2_W-1:0]   port2_pins,
  input wire logic              pad_drive_strength_select,
  input wire logic              port0_irq_req,
  input wire logic              port1_irq_req,
  input wire logic              port2_irq_req,
  input wire logic              irq
);
  // pin history is meaningless until the synchroniser has refilled
  logic [2:0] age_q;
  logic [2:0] age_d;

  always_comb age_d = (age_q == 3'h7) ? age_q : age_q + 3'h1;
  always_ff @(posedge mclk or posedge rst)
    if (rst)
      age_q <= 3'h0;
    else
      age_q <= age_d;

  default clocking @(posedge mclk); endclocking
  default disable iff (rst);

  sequence ctrl_wr_s;
    wr_en && addr == OFS_PORT_CTRL;
  endsequence
  sequence req_rose_s;
    $rose(port0_irq_req) || $rose(port1_irq_req) || $rose(port2_irq_req);
  endsequence

  rd_idle_zero_a: assert property (!$past(rd_en) |-> rd_data == 8'h00)
    else $error("read data not zero outside read cycle");
  ctrl_top_zero_a: assert property (rd_en && addr == OFS_PORT_CTRL |=> !rd_data[7])
    else $error("control top bit reads one");
  unmapped_zero_a: assert property (rd_en && addr == 8'h00 |=> rd_data == 8'h00)
    else $error("unmapped read not zero");
  pad_write_a: assert property (ctrl_wr_s |=> pad_drive_strength_select == $past(wr_data[6]))
    else $error("pad drive select not written");
  pad_hold_a: assert property (!(wr_en && addr == OFS_PORT_CTRL) |=> $stable(pad_drive_strength_select))
    else $error("pad drive select changed without write");
  port0_req_cause_a: assert property ($rose(port0_irq_req) && age_q == 3'h7
    |-> $past(wr_en) || $past(port0_pins, 2) != $past(port0_pins, 5))
    else $error("port 0 request without pin change");
  port1_req_cause_a: assert property ($rose(port1_irq_req) && age_q == 3'h7
    |-> $past(wr_en) || $past(port1_pins, 2) != $past(port1_pins, 5))
    else $error("port 1 request without pin change");
  port2_req_cause_a: assert property ($rose(port2_irq_req) && age_q == 3'h7
    |-> $past(wr_en) || $past(port2_pins, 2) != $past(port2_pins, 5))
    else $error("port 2 request without pin change");
  req_fall_a: assert property ($fell(port0_irq_req) || $fell(port1_irq_req)
    || $fell(port2_irq_req) |-> $past(wr_en) || $past(wr_en, 2))
    else $error("request dropped without write");
  irq_fall_a: assert property ($fell(irq) |-> $past(wr_en) || $past(wr_en, 2))
    else $error("interrupt dropped without write");
  req_seen_c: cover property (req_rose_s);
endmodule

bind port_irq_ctrl port_irq_ctrl_assertions #(.P0_W(P0_W), .P1_W(P1_W), .P2_W(P2_W)) i_chk (
  .mclk(mclk), .rst(rst), .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
  .rd_data(rd_data), .port0_pins(port0_pins), .port1_pins(port1_pins),
  .port2_pins(port2_pins), .pad_drive_strength_select(pad_drive_strength_select),
  .port0_irq_req(port0_irq_req), .port1_irq_req(port1_irq_req),
  .port2_irq_req(port2_irq_req), .irq(irq));

// >>> test/port_pin_interrupt_control_tb.sv
`timescale 1ns/10ps
module port_pin_interrupt_control_tb;
  import port_irq_pkg::*;
  logic       mclk;
  logic       rst;
  logic [7:0] addr;
  logic [7:0] wr_data;
  logic       wr_en;
  logic       rd_en;
  logic [7:0] rd_data;
  logic [7:0] p0;
  logic [7:0] p1;
  logic [4:0] p2;
  logic       pad;
  logic [2:0] req;
  logic       irq;
  logic       irq_on;
  int         bad_count;
  int         checks_done;

  port_irq_ctrl i_dut (.mclk(mclk), .rst(rst), .addr(addr), .wr_data(wr_data),
    .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .port0_pins(p0), .port1_pins(p1),
    .port2_pins(p2), .pad_drive_strength_select(pad), .port0_irq_req(req[0]),
    .port1_irq_req(req[1]), .port2_irq_req(req[2]), .irq(irq));

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge mclk);
    wr_en <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge mclk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge mclk);
    rd_en <= 1'b0;
    #1;
    check($sformatf("reg %h", a), rd_data, exp);
  endtask

  // one rising then one falling edge on a single pin, flags cleared after each
  task automatic edge_case(input int p, input int b, input logic [7:0] ctrl, input logic en);
    logic [7:0] fl;
    wr(OFS_PORT_CTRL, ctrl);
    for (int v = 1; v >= 0; v--)
    begin
      @(posedge mclk);
      case (p)
        0: p0[b] <= v[0];
        1: p1[b] <= v[0];
        default: p2[b] <= v[0];
      endcase
      repeat (5) @(posedge mclk);
      #1;
      fl = (v[0] != ctrl[p]) ? (8'h01 << b) : 8'h00;
      check("request", {7'h00, req[p]}, {7'h00, en && fl != 8'h00});
      check("irq", {7'h00, irq}, {7'h00, en && irq_on && fl != 8'h00});
      rd(OFS_PORT0_FLAGS + 8'(p), fl);
      rd(OFS_IRQ_STATUS, (en && fl != 8'h00) ? (8'h01 << p) : 8'h00);
      wr(OFS_PORT0_FLAGS + 8'(p), 8'h00);
      wr(OFS_IRQ_STATUS, 8'h07);
      rd(OFS_IRQ_STATUS, 8'h00);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  initial
  begin
    #200_000;
    bad_count++;
    wrap_up();
  end

  initial
  begin
    rst = 1'b1;
    addr = 8'h00;
    wr_data = 8'h00;
    wr_en = 1'b0;
    rd_en = 1'b0;
    p0 = 8'h00;
    p1 = 8'h00;
    p2 = 5'h00;
    irq_on = 1'b1;
    bad_count = 0;
    checks_done = 0;
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    rd(OFS_PORT_CTRL, 8'h00);
    rd(OFS_PORT1_MASK, 8'h00);
    check("pad select", {7'h00, pad}, 8'h00);
    wr(OFS_PORT_CTRL, 8'hff);
    #1;
    check("pad select", {7'h00, pad}, 8'h01);
    rd(OFS_PORT_CTRL, 8'h7f);
    wr(8'h00, 8'h55);
    rd(8'h00, 8'h00);
    $display("test registers done");
    wr(OFS_IRQ_MASK, 8'h07);
    wr(OFS_PORT1_MASK, 8'hf7);
    edge_case(0, 0, 8'h08, 1'b1);
    edge_case(0, 7, 8'h11, 1'b1);
    edge_case(0, 1, 8'h10, 1'b0);
    edge_case(0, 6, 8'h08, 1'b0);
    $display("test port 0 done");
    edge_case(1, 5, 8'h02, 1'b1);
    edge_case(1, 2, 8'h00, 1'b1);
    edge_case(1, 3, 8'h02, 1'b0);
    $display("test port 1 done");
    edge_case(2, 4, 8'h24, 1'b1);
    edge_case(2, 0, 8'h20, 1'b1);
    edge_case(2, 2, 8'h04, 1'b0);
    irq_on = 1'b0;
    wr(OFS_IRQ_MASK, 8'h00);
    edge_case(2, 1, 8'h60, 1'b1);
    check("pad select", {7'h00, pad}, 8'h01);
    $display("test port 2 done");
    wrap_up();
  end
endmodule
